// [hdl/bus_error_capture_decode.sv]
// bus error status, timeout address capture, retry timer and address decoder
`include "bus_error_consts.svh"

module bus_error_capture_decode
	import bus_error_pkg::*;
#(
	parameter int TIMEOUT_TICKS = `TIMEOUT_BUS_CYCLES
) (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  regAddr,
	input  wire logic [31:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [31:0] regRdata,
	output logic             busTick,
	input  wire logic        cycStart,
	input  wire logic        cycIfetch,
	input  wire logic        cycRead,
	input  wire logic [29:0] cycAddr,
	input  wire logic [1:0]  cycMode,
	input  wire logic        cycProt,
	input  wire logic        cnfValid,
	input  wire cnf_t        confirmationLines,
	input  wire logic        arbGrant,
	input  wire logic        readDataEvt,
	input  wire logic        readDataCrd,
	input  wire logic        readDataRds,
	output logic             retryReq,
	output logic             arbReq,
	output logic             cycDone,
	output logic             machineCheck,
	output logic             rdsIrq,
	input  wire logic [29:0] decAddr,
	input  wire logic [15:0] storageNodeMask,
	output logic             decMemory,
	output logic             decIo,
	output logic             decIllegal,
	output logic             decAdapterSel,
	output logic      [1:0]  decAdapterNum,
	output logic      [17:0] decDevAddr,
	output logic             decNodeSel,
	output logic      [3:0]  decArbLevel,
	output logic             decDriveSel,
	output logic      [2:0]  decDrive,
	output logic      [4:0]  decDriveReg,
	output logic             decIntRegSel,
	output logic      [12:0] decIntOffset,
	output logic             decMapReg,
	output logic             decNonMapReg
);

	localparam int TICK_DIV = `BUS_TICK_DIV;

	// ---------------- bus cycle enable
	logic [7:0] divCnt_q;
	logic       tickNow;

	assign tickNow = (divCnt_q == 8'(TICK_DIV - 1));
	assign busTick = tickNow;

	always_ff @(posedge mclk) begin
		if (!rst_n || tickNow) begin
			divCnt_q <= 8'h00;
		end else begin
			divCnt_q <= divCnt_q + 8'h01;
		end
	end

	// ---------------- cycle retry and timeout engine
	cycState_t  state_q;
	cycState_t  state_d;
	logic [9:0] toCnt_q;
	logic       srcIfetch_q;
	logic       srcRead_q;
	cnf_t       lastCnf_q;
	logic [29:0] capAddr_q;
	logic [1:0]  capMode_q;
	logic        capProt_q;

	wire active     = (state_q != CYC_IDLE);
	wire limitHit   = active && tickNow && (toCnt_q == 10'(TIMEOUT_TICKS - 1));
	wire cnfHere    = (state_q == CYC_WAIT_CNF) && cnfValid;
	wire gotNoResp  = cnfHere && (confirmationLines == `CNF_NO_RESPONSE);
	wire gotBusy    = cnfHere && (confirmationLines == `CNF_BUSY);
	wire gotAck     = cnfHere && (confirmationLines == `CNF_ACK);
	wire gotErr     = cnfHere && (confirmationLines == `CNF_ERROR);
	wire dataHere   = (state_q == CYC_WAIT_DATA) && readDataEvt;
	wire timeoutEvt = limitHit && !gotAck && !gotErr && !dataHere;

	// timeout class follows where the cycle was stuck when the limit hit
	logic [2:0] toCode;
	assign toCode = (state_q == CYC_WAIT_DATA) ? `TO_WAIT_DATA :
		(lastCnf_q == `CNF_BUSY) ? `TO_DEVICE_BUSY : `TO_NO_RESPONSE;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			CYC_IDLE: begin
				if (cycStart) begin
					state_d = CYC_WAIT_CNF;
				end
			end
			CYC_WAIT_CNF: begin
				if (gotAck) begin
					state_d = srcRead_q ? CYC_WAIT_DATA : CYC_IDLE;
				end else if (gotErr) begin
					state_d = CYC_IDLE;
				end else if (gotNoResp || gotBusy) begin
					state_d = CYC_HOLD;
				end
			end
			CYC_HOLD: begin
				if (tickNow) begin
					state_d = (lastCnf_q == `CNF_BUSY) ? CYC_ARB : CYC_WAIT_CNF;
				end
			end
			CYC_ARB: begin
				if (arbGrant) begin
					state_d = CYC_WAIT_CNF;
				end
			end
			CYC_WAIT_DATA: begin
				if (readDataEvt) begin
					state_d = CYC_IDLE;
				end
			end
		endcase
		if (timeoutEvt) begin
			state_d = CYC_IDLE;
		end
	end

	wire holdDone = (state_q == CYC_HOLD) && tickNow;

	assign retryReq = ((holdDone && (lastCnf_q != `CNF_BUSY)) ||
		((state_q == CYC_ARB) && arbGrant)) && !timeoutEvt;
	assign arbReq   = (state_q == CYC_ARB);
	assign cycDone  = (gotAck && !srcRead_q) || gotErr || dataHere;
	assign machineCheck = timeoutEvt || gotErr;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_q <= CYC_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// counted in bus cycles from the first command/address attempt
	always_ff @(posedge mclk) begin
		if (!rst_n || (state_q == CYC_IDLE)) begin
			toCnt_q <= 10'h000;
		end else if (tickNow) begin
			toCnt_q <= toCnt_q + 10'h001;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			srcIfetch_q <= 1'b0;
			srcRead_q   <= 1'b0;
			capAddr_q   <= 30'h0000_0000;
			capMode_q   <= 2'h0;
			capProt_q   <= 1'b0;
		end else if (cycStart && !active) begin
			srcIfetch_q <= cycIfetch;
			srcRead_q   <= cycRead || cycIfetch;
			capAddr_q   <= cycAddr;
			capMode_q   <= cycMode;
			capProt_q   <= cycProt;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n || (cycStart && !active)) begin
			lastCnf_q <= `CNF_ACK;
		end else if (cnfHere) begin
			lastCnf_q <= confirmationLines;
		end
	end

	// ---------------- error status register
	logic [15:0] status_q;
	logic [15:0] status_d;
	logic [31:0] toAddr_q;

	wire wrStatus = regWr && (regAddr == `REG_ERR_STATUS);
	wire [15:0] clrVec = wrStatus ? (regWdata[15:0] & `ST_W1C_MASK) : 16'h0000;

	wire mcTimeout = timeoutEvt && !srcIfetch_q;
	wire ifTimeout = timeoutEvt && srcIfetch_q;
	wire mcErr     = gotErr && !srcIfetch_q;
	wire ifErr     = gotErr && srcIfetch_q;
	wire mcEvent   = mcTimeout || mcErr;
	wire mcPending = status_q[`ST_MC_TO_HI] || status_q[`ST_MC_ERRCNF];

	logic [15:0] setVec;
	always_comb begin
		setVec = 16'h0000;
		setVec[`ST_CRD]       = dataHere && readDataCrd;
		setVec[`ST_RDS]       = dataHere && readDataRds && !srcIfetch_q;
		setVec[`ST_IF_RDS]    = dataHere && readDataRds && srcIfetch_q;
		setVec[`ST_MC_ERRCNF] = mcErr;
		setVec[`ST_IF_ERRCNF] = ifErr;
		setVec[`ST_MC_MULTI]  = mcEvent && mcPending;
	end

	// a 1 written to a field's top bit clears the whole code; a new timeout wins
	wire [2:0] mcField = mcTimeout ? toCode :
		clrVec[`ST_MC_TO_HI] ? 3'h0 : status_q[`ST_MC_TO_HI:`ST_MC_TO_LO];
	wire [2:0] ifField = ifTimeout ? toCode :
		clrVec[`ST_IF_TO_HI] ? 3'h0 : status_q[`ST_IF_TO_HI:`ST_IF_TO_LO];

	always_comb begin
		status_d = (status_q & ~clrVec) | setVec;
		status_d[`ST_RDS_IRQ_EN] = wrStatus ? regWdata[`ST_RDS_IRQ_EN] : status_q[`ST_RDS_IRQ_EN];
		status_d[`ST_MC_TO_HI:`ST_MC_TO_LO] = mcField;
		status_d[`ST_IF_TO_HI:`ST_IF_TO_LO] = ifField;
		status_d[`ST_BUS_NOT_BUSY] = 1'b0;
		status_d[9] = 1'b0;
		status_d[0] = 1'b0;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			status_q <= `ERR_STATUS_RESET;
		end else begin
			status_q <= status_d;
		end
	end

	// level, held until software clears both substitute flags or the enable
	assign rdsIrq = status_q[`ST_RDS_IRQ_EN] && (status_q[`ST_RDS] || status_q[`ST_IF_RDS]);

	// ---------------- timeout address capture
	wire [31:0] toAddrNew = {capMode_q, capProt_q, 1'b0, capAddr_q[29:2]};

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			toAddr_q <= `TIMEOUT_ADDR_RESET;
		end else if (mcTimeout) begin
			toAddr_q <= toAddrNew;
		end
	end

	// ---------------- register read port
	wire [15:0] statusView = {status_q[15:2], !active, 1'b0};
	wire [31:0] rdMux = (regAddr == `REG_ERR_STATUS)   ? {16'h0000, statusView} :
		(regAddr == `REG_TIMEOUT_ADDR) ? toAddr_q : 32'h0000_0000;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			regRdata <= 32'h0000_0000;
		end else if (regRd) begin
			regRdata <= rdMux;
		end
	end

	// ---------------- physical byte address decoder
	wire aIo      = decAddr[`PA_IO_BIT];
	wire aAdapter = decAddr[`PA_ADAPTER_BIT];
	wire aHighBad = |decAddr[28:21];
	wire aNodeBad = !aAdapter && (decAddr[`PA_NODE_MBZ_BIT] || (|decAddr[19:18]));
	wire aIllegal = aIo && (aHighBad || aNodeBad);
	wire aNode    = aIo && !aHighBad && !aAdapter && !aNodeBad;
	wire aStorage = aNode && storageNodeMask[decAddr[16:13]];
	wire aDrive   = aStorage && (decAddr[12:10] == `PA_DRIVE_SEL_CODE);
	wire aIntReg  = aStorage && !aDrive;
	wire aMap     = aIntReg && (decAddr[12:0] >= `MAP_FIRST_OFFSET);
	wire aNonMap  = aIntReg && (decAddr[12:0] <= `NONMAP_LAST_OFFSET);

	// registered so decode results line up with the data output timing
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			decMemory     <= 1'b0;
			decIo         <= 1'b0;
			decIllegal    <= 1'b0;
			decAdapterSel <= 1'b0;
			decAdapterNum <= 2'h0;
			decDevAddr    <= 18'h0_0000;
			decNodeSel    <= 1'b0;
			decArbLevel   <= 4'h0;
			decDriveSel   <= 1'b0;
			decDrive      <= 3'h0;
			decDriveReg   <= 5'h00;
			decIntRegSel  <= 1'b0;
			decIntOffset  <= 13'h0000;
			decMapReg     <= 1'b0;
			decNonMapReg  <= 1'b0;
		end else begin
			decMemory     <= !aIo;
			decIo         <= aIo;
			decIllegal    <= aIllegal;
			decAdapterSel <= aIo && !aHighBad && aAdapter;
			decAdapterNum <= decAddr[19:18];
			decDevAddr    <= decAddr[17:0];
			decNodeSel    <= aNode;
			decArbLevel   <= decAddr[16:13];
			decDriveSel   <= aDrive;
			decDrive      <= decAddr[9:7];
			decDriveReg   <= decAddr[6:2];
			decIntRegSel  <= aIntReg;
			decIntOffset  <= decAddr[12:0];
			decMapReg     <= aMap;
			decNonMapReg  <= aNonMap;
		end
	end

endmodule : bus_error_capture_decode

// [hdl/bus_error_consts.svh]
// constants for the backplane bus error capture and address decode block
`ifndef BUS_ERROR_CONSTS_SVH
`define BUS_ERROR_CONSTS_SVH

`define REG_ADDR_W           8
`define REG_ERR_STATUS       8'h19
`define REG_TIMEOUT_ADDR     8'h1a
`define ERR_STATUS_RESET     16'h0000
`define TIMEOUT_ADDR_RESET   32'h0000_0000

`define ST_RDS_IRQ_EN        15
`define ST_CRD               14
`define ST_RDS               13
`define ST_MC_TO_HI          12
`define ST_MC_TO_LO          10
`define ST_MC_ERRCNF         8
`define ST_IF_RDS            7
`define ST_IF_TO_HI          6
`define ST_IF_TO_LO          4
`define ST_IF_ERRCNF         3
`define ST_MC_MULTI          2
`define ST_BUS_NOT_BUSY      1
`define ST_W1C_MASK          16'h7dfc

`define TO_NO_RESPONSE       3'h4
`define TO_DEVICE_BUSY       3'h5
`define TO_WAIT_DATA         3'h6

`define TA_MODE_HI           31
`define TA_MODE_LO           30
`define TA_PROT              29

`define CNF_NO_RESPONSE      2'h0
`define CNF_ACK              2'h1
`define CNF_BUSY             2'h2
`define CNF_ERROR            2'h3

`define TIMEOUT_BUS_CYCLES   512
`define MCLK_PERIOD_NS       10
`define BUS_CYCLE_NS         200
`define BUS_TICK_DIV         (`BUS_CYCLE_NS / `MCLK_PERIOD_NS)

`define PA_IO_BIT            29
`define PA_ADAPTER_BIT       20
`define PA_NODE_MBZ_BIT      17
`define PA_DRIVE_SEL_CODE    3'h1
`define NONMAP_LAST_OFFSET   13'h03fc
`define MAP_FIRST_OFFSET     13'h0800

`endif

// [hdl/bus_error_pkg.sv]
// types for the backplane bus error capture and address decode block
package bus_error_pkg;

	typedef enum logic [2:0] {
		CYC_IDLE,
		CYC_WAIT_CNF,
		CYC_HOLD,
		CYC_ARB,
		CYC_WAIT_DATA
	} cycState_t;

	typedef logic [1:0] cnf_t;

endpackage : bus_error_pkg

// [sim/bus_error_capture_decode_sva.sv]
// checker for the bus error capture and decode block
module bus_error_capture_decode_sva
	import bus_error_pkg::*;
#(
	parameter int TIMEOUT_TICKS = 512
) (
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic [7:0]  regAddr,
	input wire logic        regRd,
	input wire logic [31:0] regRdata,
	input wire logic        cnfValid,
	input wire cnf_t        confirmationLines,
	input wire logic        arbGrant,
	input wire logic        cycStart,
	input wire logic        retryReq,
	input wire logic        arbReq,
	input wire logic        cycDone,
	input wire logic        machineCheck,
	input wire logic        rdsIrq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// bound is tick count plus two ticks, 20 mclk per bus cycle
	localparam int LIMIT = (TIMEOUT_TICKS + 2) * 20;
	logic        stRd_q;
	logic        busy_q;
	logic [15:0] wait_q;
	always_ff @(posedge mclk) begin
		stRd_q <= regRd && regAddr == 8'h19;
		busy_q <= rst_n && (cycStart || busy_q && !cycDone && !machineCheck);
		wait_q <= busy_q ? wait_q + 16'h0001 : 16'h0000;
	end
	property p_irq;
		stRd_q && regRdata[15] && (regRdata[13] || regRdata[7]) |-> rdsIrq;
	endproperty
	a_irq: assert property (p_irq) else $error("bad data interrupt missing");
	property p_codes;
		stRd_q |-> regRdata[31:16] == 16'h0000 && regRdata[12:10] != 3'h7 && regRdata[6:4] != 3'h7
			&& (regRdata[12] || regRdata[11:10] == 2'h0);
	endproperty
	a_codes: assert property (p_codes) else $error("illegal timeout code");
	property p_retry;
		cnfValid && confirmationLines == 2'h0 |-> ##[1:21] (retryReq || machineCheck);
	endproperty
	a_retry: assert property (p_retry) else $error("no retry after no response");
	property p_busy;
		cnfValid && confirmationLines == 2'h2 |-> ##[1:21] (arbReq || machineCheck);
	endproperty
	a_busy: assert property (p_busy) else $error("no arbitration after busy");
	property p_grant;
		arbReq && arbGrant |-> ##[0:1] (retryReq || machineCheck);
	endproperty
	a_grant: assert property (p_grant) else $error("no retry after grant");
	property p_err;
		cnfValid && confirmationLines == 2'h3 |-> cycDone && machineCheck;
	endproperty
	a_err: assert property (p_err) else $error("error answer not reported");
	property p_limit;
		busy_q |-> wait_q <= LIMIT;
	endproperty
	a_limit: assert property (p_limit) else $error("cycle outlived timeout");
	property p_ack;
		cnfValid && confirmationLines == 2'h1 |-> !machineCheck;
	endproperty
	a_ack: assert property (p_ack) else $error("machine check on ack");
	c_done: cover property (cycDone && !machineCheck);
	c_mchk: cover property (machineCheck && !cycDone);
	c_retry: cover property (retryReq);
endmodule : bus_error_capture_decode_sva

// [sim/bus_node_model.sv]
// bus node answering processor cycles with a chosen confirmation
module bus_node_model
	import bus_error_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       cycStart,
	input  wire logic       cycRead,
	input  wire logic       retryReq,
	input  wire logic       arbReq,
	input  wire logic       machineCheck,
	input  wire cnf_t       answer,
	input  wire logic       withhold,
	input  wire logic [1:0] quality,
	output logic            cnfValid,
	output cnf_t            confirmationLines,
	output logic            arbGrant,
	output logic            readDataEvt,
	output logic            readDataCrd,
	output logic            readDataRds
);
	logic [1:0] cnfDly_q;
	logic [2:0] dataDly_q;
	logic       rdFlag_q;
	cnf_t       last_q;
	logic       live;
	assign live = rst_n & !machineCheck;
	assign cnfValid = cnfDly_q[1];
	// idle lines show the inverse of the last code so stale values never match
	assign confirmationLines = cnfValid ? answer : ~last_q;
	assign readDataEvt = dataDly_q[2];
	assign readDataCrd = readDataEvt ? quality[1] : !quality[1];
	assign readDataRds = readDataEvt ? quality[0] : !quality[0];
	always_ff @(posedge mclk) begin
		cnfDly_q  <= {cnfDly_q[0], cycStart | retryReq} & {2{live}};
		dataDly_q <= {dataDly_q[1:0], cnfValid & answer == 2'h1 & rdFlag_q & !withhold} & {3{live}};
		rdFlag_q  <= cycStart ? cycRead : rdFlag_q;
		arbGrant  <= rst_n & arbReq & !arbGrant;
		last_q    <= cnfValid ? answer : last_q;
	end
endmodule : bus_node_model

// [sim/bus_error_capture_decode_tb.sv]
// register, cycle engine and decoder tests for the error capture block
module bus_error_capture_decode_tb
	import bus_error_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0, withhold = 1'b0;
	logic        cycStart = 1'b0, cycIfetch = 1'b0, cycRead = 1'b0, cycProt = 1'b0;
	logic [1:0]  cycMode = 2'h0, quality = 2'h0, decAdapterNum;
	logic [7:0]  regAddr = 8'h00;
	logic [29:0] cycAddr = 30'h0000_0000, decAddr = 30'h0000_0000, a;
	logic [31:0] regWdata = 32'h0000_0000, regRdata;
	logic [15:0] storageNodeMask = 16'h0100;
	cnf_t        answer = 2'h1, confirmationLines, c;
	logic        busTick, cnfValid, arbGrant, readDataEvt, readDataCrd, readDataRds, retryReq;
	logic        arbReq, cycDone, machineCheck, rdsIrq, decMemory, decIo, decIllegal, decAdapterSel;
	logic        decNodeSel, decDriveSel, decIntRegSel, decMapReg, decNonMapReg;
	logic [17:0] decDevAddr;
	logic [3:0]  decArbLevel;
	logic [2:0]  decDrive, code;
	logic [4:0]  decDriveReg;
	logic [12:0] decIntOffset;
	int          fail_count = 0, n_checks = 0, k;
	logic [38:0] decTab [9] = '{{30'h0000_1234, 9'h100}, {30'h2020_0000, 9'h0c0}, {30'h201c_1234, 9'h0a0},
		{30'h2000_6004, 9'h090}, {30'h2002_6004, 9'h0c0}, {30'h2004_6004, 9'h0c0},
		{30'h2001_068c, 9'h098}, {30'h2001_03fc, 9'h095}, {30'h2001_0800, 9'h096}};
	bus_error_capture_decode #(.TIMEOUT_TICKS(4)) bus_error_capture_decode_inst (.mclk, .rst_n, .regAddr,
		.regWdata, .regWr, .regRd, .regRdata, .busTick, .cycStart, .cycIfetch, .cycRead, .cycAddr, .cycMode,
		.cycProt, .cnfValid, .confirmationLines, .arbGrant, .readDataEvt, .readDataCrd, .readDataRds,
		.retryReq, .arbReq, .cycDone, .machineCheck, .rdsIrq, .decAddr, .storageNodeMask, .decMemory, .decIo,
		.decIllegal, .decAdapterSel, .decAdapterNum, .decDevAddr, .decNodeSel, .decArbLevel, .decDriveSel,
		.decDrive, .decDriveReg, .decIntRegSel, .decIntOffset, .decMapReg, .decNonMapReg);
	bus_node_model bus_node_model_inst (.mclk, .rst_n, .cycStart, .cycRead, .retryReq, .arbReq,
		.machineCheck, .answer, .withhold, .quality, .cnfValid, .confirmationLines, .arbGrant,
		.readDataEvt, .readDataCrd, .readDataRds);
	always #5 mclk = ~mclk;
	task automatic cmp(string what, logic [63:0] exp, logic [63:0] got);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp
	task automatic wr(logic [7:0] ad, logic [31:0] d);
		@(posedge mclk);
		regAddr  <= ad;
		regWdata <= d;
		regWr    <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask : wr
	task automatic rd(logic [7:0] ad, logic [31:0] exp);
		@(posedge mclk);
		regAddr <= ad;
		regRd   <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		#1 cmp("regRdata", exp, regRdata);
	endtask : rd
	// mode and protection ride on the low address bits to keep calls short
	task automatic cyc(logic f, logic r, logic [29:0] ad, cnf_t cn, logic w, logic [1:0] q);
		int n;
		@(posedge mclk);
		{answer, withhold, quality} <= {cn, w, q};
		{cycStart, cycIfetch, cycRead, cycAddr} <= {1'b1, f, r, ad};
		{cycMode, cycProt} <= ad[2:0];
		@(posedge mclk);
		cycStart <= 1'b0;
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (!(cycDone | machineCheck) && n < 400);
		if (n >= 400) cmp("cycle end", 64'h1, 64'h0);
		cmp("done and check", (cn == 2'h3) ? 64'h3 : (cn == 2'h1 && !(w && r)) ? 64'h2 : 64'h1,
			{cycDone, machineCheck});
		@(posedge mclk);
	endtask : cyc
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run
	initial begin
		#100000;
		fail_count++;
		complete_run();
	end
	initial begin
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		rd(8'h19, 32'h0000_0002);
		rd(8'h1a, 32'h0000_0000);
		rd(8'h55, 32'h0000_0000);
		wr(8'h19, 32'h0000_8000);
		rd(8'h19, 32'h0000_8002);
		do @(negedge mclk); while (!busTick);
		k = 0;
		do begin
			@(negedge mclk);
			k++;
		end while (!busTick && k < 100);
		cmp("busTick period", 64'h14, 64'(k));
		$display("test registers done");
		cyc(1'b0, 1'b1, 30'h0000_0100, 2'h1, 1'b0, 2'h2);
		rd(8'h19, 32'h0000_c002);
		cmp("rdsIrq", 64'h0, rdsIrq);
		cyc(1'b0, 1'b1, 30'h0000_0104, 2'h1, 1'b0, 2'h1);
		rd(8'h19, 32'h0000_e002);
		cmp("rdsIrq", 64'h1, rdsIrq);
		wr(8'h19, 32'h0000_fdfc);
		rd(8'h19, 32'h0000_8002);
		cyc(1'b1, 1'b1, 30'h0000_0108, 2'h1, 1'b0, 2'h1);
		rd(8'h19, 32'h0000_8082);
		cmp("rdsIrq", 64'h1, rdsIrq);
		wr(8'h19, 32'h0000_8080);
		$display("test read data done");
		cyc(1'b0, 1'b0, 30'h2000_6004, 2'h3, 1'b0, 2'h0);
		rd(8'h19, 32'h0000_8102);
		cyc(1'b0, 1'b0, 30'h2000_6004, 2'h3, 1'b0, 2'h0);
		rd(8'h19, 32'h0000_8106);
		wr(8'h19, 32'h0000_8104);
		cyc(1'b1, 1'b1, 30'h2000_6004, 2'h3, 1'b0, 2'h0);
		rd(8'h19, 32'h0000_800a);
		wr(8'h19, 32'h0000_8008);
		$display("test error answers done");
		for (int i = 0; i < 4; i++) begin
			a = 30'h3abc_def0 + 30'(i * 5);
			c = i % 3 == 1 ? 2'h2 : i % 3 == 2 ? 2'h1 : 2'h0;
			code = 3'(4 + i % 3);
			cyc(1'b0, 1'b1, a, c, 1'b1, 2'h0);
			rd(8'h19, 32'h0000_8002 | 32'(code) << 10);
			rd(8'h1a, {a[2:1], a[0], 1'b0, a[29:2]});
			wr(8'h19, 32'h0000_9000);
			cyc(1'b1, 1'b1, 30'h0000_0010, c, 1'b1, 2'h0);
			rd(8'h19, 32'h0000_8002 | 32'(code) << 4);
			rd(8'h1a, {a[2:1], a[0], 1'b0, a[29:2]});
			wr(8'h19, 32'h0000_8040);
		end
		$display("test timeouts done");
		foreach (decTab[i]) begin
			@(posedge mclk);
			decAddr <= decTab[i][38:9];
			a = decTab[i][38:9];
			@(posedge mclk);
			#1 cmp("decode flags", decTab[i][8:0], {decMemory, decIo, decIllegal, decAdapterSel, decNodeSel,
				decDriveSel, decIntRegSel, decMapReg, decNonMapReg} & (decTab[i][6] ? 9'h1c0 : 9'h1ff));
			if (decTab[i][5]) cmp("adapter", {a[19:18], a[17:0]}, {decAdapterNum, decDevAddr});
			if (decTab[i][4]) cmp("arb level", a[16:13], decArbLevel);
			if (decTab[i][3]) cmp("drive", a[9:2], {decDrive, decDriveReg});
			if (decTab[i][2]) cmp("offset", a[12:0], decIntOffset);
		end
		$display("test decoder done");
		complete_run();
	end
endmodule : bus_error_capture_decode_tb
bind bus_error_capture_decode bus_error_capture_decode_sva #(.TIMEOUT_TICKS(TIMEOUT_TICKS))
	bus_error_capture_decode_sva_inst (.mclk, .rst_n, .regAddr, .regRd, .regRdata, .cnfValid,
	.confirmationLines, .arbGrant, .cycStart, .retryReq, .arbReq, .cycDone, .machineCheck, .rdsIrq);
